/* File: hdl/t1cr_map.svh */
// Register offsets, field positions, reset values and framing constants.
`ifndef T1CR_MAP_SVH
`define T1CR_MAP_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define T1CR_OFS_CTRL 4'h0
`define T1CR_OFS_STATUS 4'h1
`define T1CR_OFS_RESULT 4'h2
`define T1CR_OFS_DATA 4'h3

// ----------------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------------
`define T1CR_CTRL_START 0
`define T1CR_CTRL_RISE 1
`define T1CR_CTRL_INVERT 2
`define T1CR_CTRL_ABORT_EN 3
`define T1CR_CTRL_CANCEL 4

// ----------------------------------------------------------------------
// Reset values and framing
// ----------------------------------------------------------------------
`define T1CR_CTRL_RST 3'h0
`define T1CR_START_SENT 6'h05
`define T1CR_END_SENT 6'h0F
`define T1CR_MAX_CHARS 7'h4F
`define T1CR_MAX_STORED 7'h4E
`define T1CR_LAST_BIT 3'h6
`define T1CR_RESULT_ERR 16'hFFFF
`define T1CR_FIFO_DEPTH 8
`define T1CR_FIFO_WIDTH 8

`endif

/* File: hdl/t1cr_pkg.sv */
// Types shared by the track 1 card reader input block.
package t1cr_pkg;

  // --------------------------------------------------------------------
  // Transfer states
  // --------------------------------------------------------------------
  typedef enum logic [3:0] {
    T1CR_IDLE  = 4'h1,
    T1CR_HUNT  = 4'h2,
    T1CR_FRAME = 4'h4,
    T1CR_LRC   = 4'h8
  } t1cr_state_t;

  // --------------------------------------------------------------------
  // Carriers
  // --------------------------------------------------------------------
  typedef struct packed {
    logic abort_en;
    logic invert;
    logic edge_rise;
  } t1cr_ctrl_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [3:0] addr;
    logic [15:0] wdata;
  } t1cr_bus_req_t;

  typedef struct packed {
    t1cr_state_t state;
    t1cr_ctrl_t ctrl;
    logic stb_s1;
    logic stb_s2;
    logic stb_s3;
    logic dat_s1;
    logic dat_s2;
    logic abt_s1;
    logic abt_s2;
    logic [6:0] win;
    logic [2:0] bitcnt;
    logic [6:0] chars;
    logic [5:0] lrc;
    logic push_valid;
    logic [7:0] push_data;
    logic err;
    logic done;
    logic [6:0] count;
    logic [15:0] rdata;
  } t1cr_top_t;

endpackage : t1cr_pkg

/* File: hdl/t1cr_reader.sv */
// Track 1 card reader input: character buffer and framing top level.
//
// How it works
// - Take one data bit per active strobe edge, falling by default, LSB first.
// - Characters are six data bits plus one bit giving odd parity.
// - Discard bits until start sentinel 0x05 seen; framing begins there.
// - Accept characters until end sentinel 0x0F, then one redundancy char.
// - At most 79 characters per transfer including sentinels and LRC.
// - Store each character without parity, one per byte, sentinels kept.
// - On success report the number of bytes stored.
// - Check parity of every character and the LRC against prior ones.
// - Result reads minus one on parity, LRC, overlength or abort error.
// - The LRC character is checked but never stored.
// - Abort input, when enabled, is sampled while waiting; high ends it.
// - A control bit selects the active strobe edge; falling by default.
// - A control bit inverts the data input; not inverted by default.
// - Bit rates of at least 7246 bit/s are sustained.
// - A stalled card leaves the block waiting; the abort input ends it.
`timescale 1ns/100ps

`include "t1cr_map.svh"

// ----------------------------------------------------------------------
// Character FIFO
// ----------------------------------------------------------------------
module t1cr_fifo #(
  parameter int WIDTH = `T1CR_FIFO_WIDTH,
  parameter int DEPTH = `T1CR_FIFO_DEPTH
) (
  input wire logic mclk,
  input wire logic arst_n,
  input wire logic in_valid,
  input wire logic [WIDTH-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [WIDTH-1:0] out_data,
  input wire logic out_ready
);
  localparam int AW = $clog2(DEPTH);

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } t1cr_fifo_st_t;

  t1cr_fifo_st_t cur_ff;
  t1cr_fifo_st_t nxt_fifo;
  logic do_push;
  logic do_pop;

  assign in_ready = (cur_ff.cnt != (AW+1)'(DEPTH));
  assign out_valid = (cur_ff.cnt != '0);
  assign out_data = cur_ff.mem[cur_ff.rp];
  assign do_push = in_valid && in_ready;
  assign do_pop = out_valid && out_ready;

  always_comb begin
    nxt_fifo = cur_ff;
    if (do_push) begin
      nxt_fifo.mem[cur_ff.wp] = in_data;
      nxt_fifo.wp = cur_ff.wp + 1'b1;
    end
    if (do_pop) begin
      nxt_fifo.rp = cur_ff.rp + 1'b1;
    end
    if (do_push && !do_pop) begin
      nxt_fifo.cnt = cur_ff.cnt + 1'b1;
    end else if (do_pop && !do_push) begin
      nxt_fifo.cnt = cur_ff.cnt - 1'b1;
    end
  end

  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
    end else begin
      cur_ff <= nxt_fifo;
    end
  end

  a_fifo_count: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (do_push && !do_pop) |=> (cur_ff.cnt == $past(cur_ff.cnt) + 1'b1))
    else $error("fifo count did not follow a push");
endmodule : t1cr_fifo

// ----------------------------------------------------------------------
// Reader top level
// ----------------------------------------------------------------------
module t1cr_reader (
  input wire logic mclk,
  input wire logic arst_n,
  input wire t1cr_pkg::t1cr_bus_req_t bus_req,
  output logic [15:0] bus_rdata,
  input wire logic strobe_in,
  input wire logic data_in,
  input wire logic abort_in,
  output logic xfer_done,
  output logic xfer_err
);
  t1cr_pkg::t1cr_top_t cur_ff;
  t1cr_pkg::t1cr_top_t nxt_top;

  logic fifo_in_ready;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  logic fifo_pop;
  logic act;
  logic bitv;
  logic [6:0] ch;
  logic podd;
  logic last_bit;
  logic waiting;
  logic abort_hit;

  // --------------------------------------------------------------------
  // Sampling helpers
  // --------------------------------------------------------------------
  // Edges are found on the second and third stages of the strobe chain.
  assign act = cur_ff.ctrl.edge_rise ?
    (cur_ff.stb_s2 && !cur_ff.stb_s3) :
    (!cur_ff.stb_s2 && cur_ff.stb_s3);
  assign bitv = cur_ff.dat_s2 ^ cur_ff.ctrl.invert;
  assign ch = {bitv, cur_ff.win[6:1]};
  assign podd = ^ch;
  assign last_bit = (cur_ff.bitcnt == `T1CR_LAST_BIT);
  assign waiting = (cur_ff.state != t1cr_pkg::T1CR_IDLE);
  assign abort_hit = waiting && cur_ff.ctrl.abort_en && cur_ff.abt_s2;
  assign fifo_pop = bus_req.rd && (bus_req.addr == `T1CR_OFS_DATA) &&
    fifo_out_valid;

  assign bus_rdata = cur_ff.rdata;
  assign xfer_done = cur_ff.done;
  assign xfer_err = cur_ff.err;

  t1cr_fifo #(
    .WIDTH(`T1CR_FIFO_WIDTH),
    .DEPTH(`T1CR_FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .arst_n(arst_n),
    .in_valid(cur_ff.push_valid),
    .in_data(cur_ff.push_data),
    .in_ready(fifo_in_ready),
    .out_valid(fifo_out_valid),
    .out_data(fifo_out_data),
    .out_ready(fifo_pop)
  );

  // --------------------------------------------------------------------
  // Next state
  // --------------------------------------------------------------------
  always_comb begin
    logic fail;
    logic fin;
    logic store;
    logic [5:0] sbyte;
    fail = 1'b0;
    fin = 1'b0;
    store = 1'b0;
    sbyte = 6'h00;
    nxt_top = cur_ff;
    nxt_top.stb_s1 = strobe_in;
    nxt_top.stb_s2 = cur_ff.stb_s1;
    nxt_top.stb_s3 = cur_ff.stb_s2;
    nxt_top.dat_s1 = data_in;
    nxt_top.dat_s2 = cur_ff.dat_s1;
    nxt_top.abt_s1 = abort_in;
    nxt_top.abt_s2 = cur_ff.abt_s1;
    nxt_top.rdata = 16'h0000;
    if (cur_ff.push_valid && fifo_in_ready) begin
      nxt_top.push_valid = 1'b0;
    end

    // A stalled card keeps the block waiting until abort or cancel.
    if (abort_hit) begin
      fail = 1'b1;
    end else if (act) begin
      nxt_top.win = ch;
      case (cur_ff.state)
        t1cr_pkg::T1CR_HUNT: begin
          if (ch[5:0] == `T1CR_START_SENT && podd) begin
            store = 1'b1;
            sbyte = `T1CR_START_SENT;
            nxt_top.lrc = `T1CR_START_SENT;
            nxt_top.bitcnt = 3'h0;
            nxt_top.state = t1cr_pkg::T1CR_FRAME;
          end
        end
        t1cr_pkg::T1CR_FRAME: begin
          if (last_bit) begin
            nxt_top.bitcnt = 3'h0;
            if (!podd) begin
              fail = 1'b1;
            end else if (cur_ff.chars == `T1CR_MAX_STORED) begin
              fail = 1'b1;
            end else begin
              store = 1'b1;
              sbyte = ch[5:0];
              nxt_top.lrc = cur_ff.lrc ^ ch[5:0];
              if (ch[5:0] == `T1CR_END_SENT) begin
                nxt_top.state = t1cr_pkg::T1CR_LRC;
              end
            end
          end else begin
            nxt_top.bitcnt = cur_ff.bitcnt + 3'h1;
          end
        end
        t1cr_pkg::T1CR_LRC: begin
          if (last_bit) begin
            nxt_top.bitcnt = 3'h0;
            if (!podd || ch[5:0] != cur_ff.lrc) begin
              fail = 1'b1;
            end else begin
              fin = 1'b1;
            end
          end else begin
            nxt_top.bitcnt = cur_ff.bitcnt + 3'h1;
          end
        end
        default: begin
          nxt_top.win = cur_ff.win;
        end
      endcase
    end

    // A character that finds the previous one still waiting is an overrun.
    if (store) begin
      if (cur_ff.push_valid && !fifo_in_ready) begin
        fail = 1'b1;
      end else begin
        nxt_top.push_valid = 1'b1;
        nxt_top.push_data = {2'b00, sbyte};
        nxt_top.chars = cur_ff.chars + 7'h01;
      end
    end

    // Register writes.
    if (bus_req.wr && bus_req.addr == `T1CR_OFS_CTRL) begin
      nxt_top.ctrl.edge_rise = bus_req.wdata[`T1CR_CTRL_RISE];
      nxt_top.ctrl.invert = bus_req.wdata[`T1CR_CTRL_INVERT];
      nxt_top.ctrl.abort_en = bus_req.wdata[`T1CR_CTRL_ABORT_EN];
      if (bus_req.wdata[`T1CR_CTRL_START] && !waiting) begin
        nxt_top.state = t1cr_pkg::T1CR_HUNT;
        nxt_top.win = 7'h00;
        nxt_top.bitcnt = 3'h0;
        nxt_top.chars = 7'h00;
        nxt_top.lrc = 6'h00;
        nxt_top.err = 1'b0;
        nxt_top.done = 1'b0;
        nxt_top.count = 7'h00;
      end else if (bus_req.wdata[`T1CR_CTRL_CANCEL] && waiting) begin
        fail = 1'b1;
      end
    end

    // Completion: the result holds a count or the error mark.
    if (fail || fin) begin
      nxt_top.state = t1cr_pkg::T1CR_IDLE;
      nxt_top.done = 1'b1;
      nxt_top.err = fail;
      nxt_top.count = fail ? 7'h00 : nxt_top.chars;
    end

    // Register reads; data stand only in the following cycle.
    if (bus_req.rd) begin
      case (bus_req.addr)
        `T1CR_OFS_CTRL: begin
          nxt_top.rdata = {11'h000, 1'b0, cur_ff.ctrl.abort_en,
            cur_ff.ctrl.invert, cur_ff.ctrl.edge_rise, 1'b0};
        end
        `T1CR_OFS_STATUS: begin
          nxt_top.rdata = {12'h000, fifo_out_valid, cur_ff.err,
            cur_ff.done, waiting};
        end
        `T1CR_OFS_RESULT: begin
          nxt_top.rdata = cur_ff.err ? `T1CR_RESULT_ERR :
            {9'h000, cur_ff.count};
        end
        `T1CR_OFS_DATA: begin
          nxt_top.rdata = {7'h00, fifo_out_valid, fifo_out_data};
        end
        default: begin
          nxt_top.rdata = 16'h0000;
        end
      endcase
    end
  end

  // --------------------------------------------------------------------
  // State register
  // --------------------------------------------------------------------
  // Sampling at 40 MHz leaves far more than 7246 bit/s of headroom.
  always_ff @(posedge mclk or negedge arst_n) begin
    if (!arst_n) begin
      cur_ff <= '0;
      cur_ff.state <= t1cr_pkg::T1CR_IDLE;
      cur_ff.ctrl <= `T1CR_CTRL_RST;
    end else begin
      cur_ff <= nxt_top;
    end
  end

  // --------------------------------------------------------------------
  // Checks
  // --------------------------------------------------------------------
  a_bit_advance: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && !abort_hit && cur_ff.state == t1cr_pkg::T1CR_FRAME &&
     !last_bit && !bus_req.wr) |=>
    (cur_ff.bitcnt == $past(cur_ff.bitcnt) + 3'h1))
    else $error("bit count did not advance on active edge");

  a_start_found: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && !abort_hit && cur_ff.state == t1cr_pkg::T1CR_HUNT &&
     ch[5:0] == `T1CR_START_SENT && podd && !bus_req.wr) |=>
    (cur_ff.state == t1cr_pkg::T1CR_FRAME ||
     cur_ff.state == t1cr_pkg::T1CR_IDLE))
    else $error("start sentinel not taken");

  a_end_to_lrc: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && !abort_hit && cur_ff.state == t1cr_pkg::T1CR_FRAME &&
     last_bit && podd && ch[5:0] == `T1CR_END_SENT &&
     cur_ff.chars != `T1CR_MAX_STORED && !cur_ff.push_valid &&
     !bus_req.wr) |=> (cur_ff.state == t1cr_pkg::T1CR_LRC))
    else $error("end sentinel did not lead to check character");

  a_overlength: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && cur_ff.state == t1cr_pkg::T1CR_FRAME && last_bit &&
     cur_ff.chars == `T1CR_MAX_STORED && !bus_req.wr) |=>
    (cur_ff.err && cur_ff.done))
    else $error("overlength transfer not flagged");

  a_store_byte: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && !abort_hit && cur_ff.state == t1cr_pkg::T1CR_FRAME &&
     last_bit && podd && cur_ff.chars != `T1CR_MAX_STORED &&
     !cur_ff.push_valid && !bus_req.wr) |=>
    (cur_ff.push_valid && cur_ff.push_data == {2'b00, $past(ch[5:0])}))
    else $error("character not stored right aligned");

  a_parity_err: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && last_bit && !podd && !bus_req.wr &&
     (cur_ff.state == t1cr_pkg::T1CR_FRAME ||
      cur_ff.state == t1cr_pkg::T1CR_LRC)) |=>
    (cur_ff.err && cur_ff.state == t1cr_pkg::T1CR_IDLE))
    else $error("parity failure not flagged");

  a_abort_end: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (abort_hit && !bus_req.wr) |=>
    (cur_ff.err && cur_ff.state == t1cr_pkg::T1CR_IDLE))
    else $error("abort did not end the transfer");

  a_result_err: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (bus_req.rd && bus_req.addr == `T1CR_OFS_RESULT && cur_ff.err) |=>
    (bus_rdata == `T1CR_RESULT_ERR))
    else $error("error result is not minus one");

  a_lrc_unstored: assert property (
    @(posedge mclk) disable iff (!arst_n)
    $rose(cur_ff.push_valid) |->
    ($past(cur_ff.state) == t1cr_pkg::T1CR_FRAME ||
     $past(cur_ff.state) == t1cr_pkg::T1CR_HUNT))
    else $error("check character was stored");

  a_count_ok: assert property (
    @(posedge mclk) disable iff (!arst_n)
    (act && !abort_hit && cur_ff.state == t1cr_pkg::T1CR_LRC &&
     last_bit && podd && ch[5:0] == cur_ff.lrc && !bus_req.wr) |=>
    (!cur_ff.err && cur_ff.count == $past(cur_ff.chars)))
    else $error("success count wrong");
endmodule : t1cr_reader

/* File: bench/t1cr_card_model.sv */
// Behavioural card reader that drives the strobe and data pins.
`timescale 1ns/100ps

module t1cr_card_model (
  input logic mclk,
  output logic strobe,
  output logic data
);
  logic inv = 1'b0;

  initial begin
    strobe = 1'b1;
    data = 1'b0;
  end

  // --------------------------------------------------------------------
  // Mode and bit timing
  // --------------------------------------------------------------------
  // The strobe rests on the level before its active edge between frames.
  task automatic setup(input logic r, input logic i);
    inv = i;
    strobe <= ~r;
  endtask : setup

  // Each strobe phase lasts four clock cycles, a bit cycle of 200 ns.
  task automatic send_bit(input logic b);
    data <= b ^ inv;
    repeat (4) @(posedge mclk);
    strobe <= ~strobe;
    repeat (4) @(posedge mclk);
    strobe <= ~strobe;
  endtask : send_bit

  // Data is released to its inverse once the whole character is sent.
  task automatic send_char(input logic [5:0] c, input logic bad);
    logic [6:0] w;
    w = {~(^c) ^ bad, c};
    @(posedge mclk);
    for (int k = 0; k < 7; k++) begin
      send_bit(w[k]);
    end
    data <= ~data;
  endtask : send_char
endmodule : t1cr_card_model

/* File: bench/t1cr_reader_test.sv */
// Self-checking testbench for the track 1 card reader input block.
`timescale 1ns/100ps

module t1cr_reader_test;
  logic mclk = 1'b0;
  logic arst_n = 1'b0;
  t1cr_pkg::t1cr_bus_req_t bus_req = '0;
  logic abort_in = 1'b0;
  logic [15:0] bus_rdata;
  logic strobe_in;
  logic data_in;
  logic xfer_done;
  logic xfer_err;
  logic rd_pend = 1'b0;
  logic [31:0] exp_q[$];
  int err_count = 0;
  int check_count = 0;

  always #12.5 mclk = ~mclk;

  t1cr_card_model card (.mclk(mclk), .strobe(strobe_in), .data(data_in));

  t1cr_reader dut (.mclk(mclk), .arst_n(arst_n), .bus_req(bus_req),
    .bus_rdata(bus_rdata), .strobe_in(strobe_in), .data_in(data_in),
    .abort_in(abort_in), .xfer_done(xfer_done), .xfer_err(xfer_err));

  // --------------------------------------------------------------------
  // Checking
  // --------------------------------------------------------------------
  task automatic chk_word(input logic [15:0] got, input logic [31:0] e);
    check_count++;
    if ((got & e[31:16]) !== (e[15:0] & e[31:16])) begin
      err_count++;
      $display("ERROR %0t: read %h, expected %h", $time, got, e[15:0]);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic e);
    check_count++;
    if (got !== e) begin
      err_count++;
      $display("ERROR %0t: flag %b, expected %b", $time, got, e);
    end
  endtask : chk_bit

  // Each read result is matched against the oldest noted expectation.
  always @(posedge mclk) begin
    if (rd_pend) begin
      if (exp_q.size() == 0) begin
        err_count++;
        $display("ERROR %0t: read with no expectation", $time);
      end else begin
        chk_word(bus_rdata, exp_q.pop_front());
      end
    end
    rd_pend <= bus_req.rd;
  end

  task automatic summarize();
    if (err_count == 0 && check_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  // --------------------------------------------------------------------
  // Register bus
  // --------------------------------------------------------------------
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus_req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge mclk);
    bus_req <= '0;
  endtask : wr

  task automatic rd(input logic [3:0] a, input logic [15:0] e,
                    input logic [15:0] m);
    exp_q.push_back({m, e});
    @(posedge mclk);
    bus_req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 16'h0000};
    @(posedge mclk);
    bus_req <= '0;
  endtask : rd

  // --------------------------------------------------------------------
  // One transfer: fault 0 none, 1 parity, 2 check char, 3 overlength,
  // 4 abort, 5 buffer left undrained until it overflows
  // --------------------------------------------------------------------
  task automatic run(input logic [2:0] cfg, input int nd, input int fault);
    logic [5:0] c;
    logic [5:0] lrc;
    logic [5:0] dq[$];
    logic stop;
    int n;
    lrc = 6'h00;
    n = 0;
    stop = 1'b0;
    wr(4'h0, {12'h000, cfg, 1'b1});
    rd(4'h1, 16'h0001, 16'h0007);
    rd(4'h0, {12'h000, cfg, 1'b0}, 16'h001F);
    card.setup(cfg[0], cfg[1]);
    abort_in <= cfg[1];
    card.send_char(6'h00, 1'b1);
    card.send_char(6'h00, 1'b1);
    for (int i = 0; i <= nd + 1 && !stop; i++) begin
      c = 6'($urandom);
      if (c == 6'h0F) c = 6'h0E;
      if (i == 0) c = 6'h05;
      if (i == nd + 1 && fault != 3) c = 6'h0F;
      stop = (fault == 1 && i == 2) || (fault == 3 && i == nd + 1);
      card.send_char(c, fault == 1 && i == 2);
      if (!stop) begin
        lrc ^= c;
        n++;
        dq.push_back(c);
        repeat (4) @(posedge mclk);
        if (fault != 5) rd(4'h3, {8'h01, 2'b00, c}, 16'h01FF);
      end
      if (fault == 4 && i == 2) begin
        abort_in <= 1'b1;
        stop = 1'b1;
      end
    end
    if (!stop) card.send_char(lrc ^ {5'h00, fault == 2}, 1'b0);
    repeat (8) @(posedge mclk);
    abort_in <= 1'b0;
    @(negedge mclk);
    chk_bit(xfer_done, 1'b1);
    chk_bit(xfer_err, fault != 0);
    rd(4'h2, fault != 0 ? 16'hFFFF : 16'(n), 16'hFFFF);
    rd(4'h1, {12'h000, fault == 5, fault != 0, 2'b10}, 16'h000F);
    if (fault == 5) begin
      for (int k = 0; k < 9; k++) begin
        rd(4'h3, {8'h01, 2'b00, dq[k]}, 16'h01FF);
      end
    end
    if (fault != 1) rd(4'h3, 16'h0000, 16'h0100);
  endtask : run

  // --------------------------------------------------------------------
  // Main sequence and watchdog
  // --------------------------------------------------------------------
  initial begin
    void'($urandom(32'h0223));
    repeat (8) @(posedge mclk);
    arst_n <= 1'b1;
    for (int i = 0; i < 5; i++) begin
      rd(i == 4 ? 4'hA : 4'(i), 16'h0000, 16'hFFFF);
    end
    wr(4'hB, 16'hFFFF);
    rd(4'h0, 16'h0000, 16'hFFFF);
    run(3'b000, 6, 0);
    run(3'b011, 76, 0);
    run(3'b000, 6, 1);
    run(3'b010, 6, 2);
    run(3'b000, 77, 3);
    run(3'b100, 6, 4);
    run(3'b000, 8, 5);
    wr(4'h0, 16'h0001);
    wr(4'h0, 16'h0010);
    rd(4'h1, 16'h0006, 16'h0007);
    rd(4'h2, 16'hFFFF, 16'hFFFF);
    repeat (4) @(posedge mclk);
    summarize();
  end

  initial begin
    #1500000;
    err_count++;
    $display("ERROR %0t: watchdog expired", $time);
    summarize();
  end
endmodule : t1cr_reader_test
